// >>> rtl/flh_host_ctrl.sv
// Purpose: host-side controller driving an asynchronous parallel flash through its pins
// Assumes: CLOCK 200 MHz, RST synchronous active high; user port on the same clock
// Notes:   waits are counted in cycles; data pins are sampled through two flops
`timescale 1ns/100ps
`include "flh_defs.svh"

// Operation
// - reads hold write enable and reset high, chip select and output enable low.
// - writes drive chip select and write enable low, output enable high.
// - host waits read and write recovery after releasing reset_powerdown_n.
// - after an abort, recovery delays count from the end of abort time; an RST held two cycles or more zeroes the abort count instead.
// - host holds reset_powerdown_n low at least 100 ns to reset.
// - host writes FFH before array reads when not in read-array mode.
module flh_host_ctrl
	import flh_pkg::*;
#(
	parameter int ABORT_ERASE_CYC = `FLH_ABORT_ERASE_CYC,
	parameter int ABORT_PROG_CYC = `FLH_ABORT_PROG_CYC
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_WRITE,
	input wire logic REQ_RAW,
	input wire logic [`FLH_ADDR_W-1:0] REQ_ADDR,
	input wire logic [`FLH_DATA_W-1:0] REQ_WDATA,
	output logic RSP_VALID,
	output logic [`FLH_DATA_W-1:0] RSP_RDATA,
	input wire logic PWRDN,
	output logic OP_BUSY,
	output logic ARRAY_MODE,
	output logic CE_N,
	output logic OE_N,
	output logic WE_N,
	output logic RP_N,
	output logic [`FLH_ADDR_W-1:0] ADDR,
	output logic [`FLH_DATA_W-1:0] DQ_O,
	output logic DQ_OE_N,
	input wire logic [`FLH_DATA_W-1:0] DQ_I
);
	localparam int CW = `FLH_CNT_W;
	localparam int PULSE_CYC = `FLH_PULSE_CYC;
	localparam int REC_CYC = `FLH_REC_CYC;
	localparam int RD_CYC = `FLH_RD_CYC;

	// ****************************************
	// state
	// ****************************************
	flh_state_t state_reg, state_next;
	flh_op_t op_reg;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic [CW-1:0] abort_cnt_reg;
	logic array_reg, fix_reg, rsp_reg;
	logic [7:0] last_cmd_reg;
	logic [`FLH_DATA_W-1:0] dq_sync, rdata_reg, wdata_reg;
	logic [`FLH_ADDR_W-1:0] addr_reg;
	logic ce_n_reg, oe_n_reg, we_n_reg, rp_n_reg, dq_oe_n_reg;
	logic cnt_done, take, need_fix;

	assign cnt_done = (cnt_reg == '0);
	assign REQ_READY = (state_reg == S_IDLE) && !PWRDN;
	assign take = REQ_READY && REQ_VALID;
	assign need_fix = !REQ_WRITE && !REQ_RAW && !array_reg;

	flh_sync2 #(.W(`FLH_DATA_W)) u_dq_sync (
		.clk(CLOCK),
		.rst(RST),
		.d(DQ_I),
		.q(dq_sync)
	);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_done ? cnt_reg : cnt_reg - 1'b1;
		case (state_reg)
			S_RST: begin
				// reset low at least the pulse time; abort keeps running meanwhile
				if (cnt_done && !PWRDN) begin
					state_next = S_WAKE;
				end
			end
			S_WAKE: begin
				// recovery starts only once the abort window has closed
				if (abort_cnt_reg == '0) begin
					state_next = S_RECOV;
					cnt_next = CW'(REC_CYC - 1);
				end
			end
			S_RECOV: begin
				if (cnt_done) begin
					state_next = S_IDLE;
				end
			end
			S_IDLE: begin
				if (PWRDN) begin
					state_next = S_RST;
					cnt_next = CW'(PULSE_CYC - 1);
				end else if (take && (REQ_WRITE || need_fix)) begin
					state_next = S_WR;
					cnt_next = CW'(`FLH_WE_CYC - 1);
				end else if (take) begin
					state_next = S_RD;
					cnt_next = CW'(RD_CYC - 1);
				end
			end
			S_RD: begin
				if (cnt_done) begin
					state_next = S_GAP;
					cnt_next = CW'(`FLH_GAP_CYC - 1);
				end
			end
			S_WR: begin
				if (cnt_done) begin
					state_next = S_WRH;
					cnt_next = CW'(`FLH_HOLD_CYC - 1);
				end
			end
			S_WRH: begin
				if (cnt_done) begin
					state_next = S_GAP;
					cnt_next = CW'(`FLH_GAP_CYC - 1);
				end
			end
			S_GAP: begin
				if (cnt_done && fix_reg) begin
					state_next = S_RD;
					cnt_next = CW'(RD_CYC - 1);
				end else if (cnt_done) begin
					state_next = S_IDLE;
				end
			end
			default: begin
				state_next = S_RST;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_reg <= S_RST;
			cnt_reg <= CW'(PULSE_CYC - 1);
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// ****************************************
	// pins
	// ****************************************
	// pins follow the next state so they line up with state_reg
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rp_n_reg <= 1'b0;
			ce_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			dq_oe_n_reg <= 1'b1;
		end else begin
			rp_n_reg <= (state_next != S_RST);
			ce_n_reg <= !(state_next inside {S_RD, S_WR, S_WRH});
			oe_n_reg <= (state_next != S_RD);
			we_n_reg <= (state_next != S_WR);
			// data driven through the write enable rise so the latch edge sees it
			dq_oe_n_reg <= !(state_next inside {S_WR, S_WRH});
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			addr_reg <= '0;
			wdata_reg <= '0;
		end else if (take) begin
			addr_reg <= REQ_ADDR;
			wdata_reg <= need_fix ? `FLH_DATA_W'(`FLH_CMD_READ_ARRAY) : REQ_WDATA;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			fix_reg <= 1'b0;
		end else if (take) begin
			fix_reg <= need_fix;
		end else if (state_reg == S_RD) begin
			fix_reg <= 1'b0;
		end
	end

	// ****************************************
	// device mode tracking
	// ****************************************
	// array mode after every reset; any other command leaves it
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			array_reg <= 1'b1;
			last_cmd_reg <= 8'h00;
			op_reg <= OP_NONE;
		end else if (state_reg == S_RST) begin
			array_reg <= 1'b1;
			last_cmd_reg <= 8'h00;
			op_reg <= OP_NONE;
		end else if (state_reg == S_WR && cnt_done) begin
			if (last_cmd_reg == `FLH_CMD_PROG || last_cmd_reg == `FLH_CMD_PROG_ALT) begin
				// program data is never a command, whatever its low byte holds
				array_reg <= 1'b0;
				last_cmd_reg <= 8'h00;
				op_reg <= OP_PROG;
			end else begin
				array_reg <= (wdata_reg[7:0] == `FLH_CMD_READ_ARRAY);
				last_cmd_reg <= wdata_reg[7:0];
				if (last_cmd_reg == `FLH_CMD_ERASE && wdata_reg[7:0] == `FLH_CMD_CONFIRM) begin
					op_reg <= OP_ERASE;
				end
			end
		end else if (rsp_reg && !array_reg && rdata_reg[`FLH_SR_READY_BIT]) begin
			// any answer outside array mode, write answers too, ends the tracked operation if rdata_reg holds the ready bit
			op_reg <= OP_NONE;
		end
	end

	// abort window loads when reset is asserted over a running operation
	always_ff @(posedge CLOCK) begin
		if ((RST || (state_reg == S_IDLE && PWRDN)) && op_reg == OP_ERASE) begin
			abort_cnt_reg <= CW'(ABORT_ERASE_CYC - 1);
		end else if ((RST || (state_reg == S_IDLE && PWRDN)) && op_reg == OP_PROG) begin
			abort_cnt_reg <= CW'(ABORT_PROG_CYC - 1);
		end else if (RST) begin
			abort_cnt_reg <= '0;
		end else if (abort_cnt_reg != '0) begin
			abort_cnt_reg <= abort_cnt_reg - 1'b1;
		end
	end

	// ****************************************
	// read data
	// ****************************************
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rsp_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			rsp_reg <= 1'b0;
			if (state_reg == S_RD && cnt_done) begin
				rdata_reg <= dq_sync;
				rsp_reg <= 1'b1;
			end else if (state_reg == S_WRH && cnt_done && !fix_reg) begin
				rsp_reg <= 1'b1;
			end
		end
	end

	assign RSP_VALID = rsp_reg;
	assign RSP_RDATA = rdata_reg;
	assign OP_BUSY = (op_reg != OP_NONE);
	assign ARRAY_MODE = array_reg;
	assign CE_N = ce_n_reg;
	assign OE_N = oe_n_reg;
	assign WE_N = we_n_reg;
	assign RP_N = rp_n_reg;
	assign ADDR = addr_reg;
	assign DQ_O = wdata_reg;
	assign DQ_OE_N = dq_oe_n_reg;

	// ****************************************
	// checks
	// ****************************************
	logic [CW-1:0] rp_low_cnt_reg, quiet_cnt_reg;
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rp_low_cnt_reg <= '0;
		end else if (!RP_N && rp_low_cnt_reg != '1) begin
			rp_low_cnt_reg <= rp_low_cnt_reg + 1'b1;
		end else if (RP_N) begin
			rp_low_cnt_reg <= '0;
		end
	end
	always_ff @(posedge CLOCK) begin
		if (RST || !RP_N || abort_cnt_reg != '0) begin
			quiet_cnt_reg <= '0;
		end else if (quiet_cnt_reg != '1) begin
			quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
		end
	end

	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);

	sequence s_rd_enter;
		state_reg != S_RD ##1 state_reg == S_RD;
	endsequence
	sequence s_fix_take;
		take && need_fix;
	endsequence

	a_read_pins: assert property (state_reg == S_RD |-> !CE_N && !OE_N && WE_N && RP_N)
		else $error("read cycle pin levels wrong");
	a_bus_free: assert property (!OE_N |-> DQ_OE_N)
		else $error("host drives data while output enable low");
	a_write_pins: assert property (!WE_N |-> !CE_N && OE_N && RP_N && !DQ_OE_N)
		else $error("write cycle pin levels wrong");
	a_read_answer: assert property (s_rd_enter |-> ##RD_CYC RSP_VALID)
		else $error("read answer not at expected cycle");
	a_reset_pulse: assert property ($rose(RP_N) |-> rp_low_cnt_reg >= PULSE_CYC)
		else $error("reset pulse shorter than minimum");
	a_recovery_wait: assert property ($fell(CE_N) |-> quiet_cnt_reg >= REC_CYC)
		else $error("access started before recovery elapsed");
	a_abort_quiet: assert property (abort_cnt_reg != '0 |-> CE_N)
		else $error("bus used during abort window");
	a_fix_first: assert property (s_fix_take |=> !WE_N && DQ_O[7:0] == 8'hff)
		else $error("read array command not issued first");
	a_pwrdn_rp: assert property (state_reg == S_IDLE && PWRDN |=> !RP_N ##1 !RP_N)
		else $error("power down did not assert reset pin");
endmodule

// >>> rtl/flh_defs.svh
// Purpose: timing counts, pin command codes and widths for the flash host controller
// Assumes: 200 MHz CLOCK; times in ns or us as named
// Notes:   cycle counts round up so every wait is at least the stated time
`ifndef FLH_DEFS_SVH
`define FLH_DEFS_SVH

// ****************************************
// clock and widths
// ****************************************
`define FLH_CLK_MHZ 200
`define FLH_ADDR_W 22
`define FLH_DATA_W 16
`define FLH_CNT_W 13

// ****************************************
// times
// ****************************************
`define FLH_RESET_PULSE_NS 100
`define FLH_READ_REC_NS 150
`define FLH_WRITE_REC_NS 150
`define FLH_ACCESS_NS 100
`define FLH_WE_PULSE_NS 50
`define FLH_DATA_HOLD_NS 20
`define FLH_GAP_NS 30
`define FLH_ABORT_ERASE_US 22
`define FLH_ABORT_PROG_US 12

// ****************************************
// cycle counts
// ****************************************
`define FLH_NS2CYC(ns) ((((ns) * `FLH_CLK_MHZ) + 999) / 1000)
`define FLH_PULSE_CYC `FLH_NS2CYC(`FLH_RESET_PULSE_NS)
`define FLH_REC_NS ((`FLH_READ_REC_NS > `FLH_WRITE_REC_NS) ? `FLH_READ_REC_NS : `FLH_WRITE_REC_NS)
`define FLH_REC_CYC `FLH_NS2CYC(`FLH_REC_NS)
`define FLH_SYNC_MARGIN 3
`define FLH_RD_CYC (`FLH_NS2CYC(`FLH_ACCESS_NS) + `FLH_SYNC_MARGIN)
`define FLH_WE_CYC `FLH_NS2CYC(`FLH_WE_PULSE_NS)
`define FLH_HOLD_CYC `FLH_NS2CYC(`FLH_DATA_HOLD_NS)
`define FLH_GAP_CYC `FLH_NS2CYC(`FLH_GAP_NS)
`define FLH_ABORT_ERASE_CYC (`FLH_ABORT_ERASE_US * `FLH_CLK_MHZ)
`define FLH_ABORT_PROG_CYC (`FLH_ABORT_PROG_US * `FLH_CLK_MHZ)

// ****************************************
// command codes and status field
// ****************************************
`define FLH_CMD_READ_ARRAY 8'hff
`define FLH_CMD_PROG 8'h40
`define FLH_CMD_PROG_ALT 8'h10
`define FLH_CMD_ERASE 8'h20
`define FLH_CMD_CONFIRM 8'hd0
`define FLH_SR_READY_BIT 7

`endif

// >>> rtl/flh_pkg.sv
// Purpose: types shared by the flash host controller
// Assumes: nothing beyond the defs header
// Notes:   encodings left to the tools
package flh_pkg;
	typedef enum logic [2:0] {
		S_RST, S_WAKE, S_RECOV, S_IDLE, S_RD, S_WR, S_WRH, S_GAP
	} flh_state_t;
	typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_ERASE} flh_op_t;
endpackage

// >>> rtl/flh_sync2.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: bits are sampled independently; callers allow settle margin
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
module flh_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// >>> sim/flh_flash_model.sv
// Purpose: behavioural flash device facing the host controller
// Assumes: times in ns; the whole array acts as one erase block
// Notes: id and query words are arbitrary values
`timescale 1ns/100ps
`include "flh_defs.svh"
module flh_flash_model #(
	parameter logic [15:0] MAKER_ID = 16'h00a5,
	parameter logic [15:0] QUERY_WORD = 16'h005a,
	parameter logic [7:0] VPP_ERR = 8'h08,
	parameter int ACC_NS = 70,
	parameter int BUSY_NS = 1500,
	parameter int ABORT_NS = 100
) (
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic rp_n,
	input wire logic [21:0] addr,
	input wire logic [15:0] din,
	input wire logic din_oe_n,
	input wire logic vpp_low,
	output logic [15:0] dout,
	output logic dout_oe_n,
	output int viol
);
	// ****************************************
	// state
	// ****************************************
	logic [15:0] mem [int];
	logic [7:0] sr = 8'h80;
	logic [7:0] pend = 8'h00;
	logic [15:0] rd;
	logic [15:0] last = 16'h0000;
	int mode = 0;
	int op_id = 0;
	int op_a = 0;
	bit busy = 0;
	realtime ready_t = 0;
	realtime rp_fall = 0;
	wire rd_en = !ce_n && !oe_n && rp_n && we_n;
	function automatic logic [15:0] rdmem(int a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction
	always @* begin
		case (mode)
			1: rd = MAKER_ID;
			2: rd = {8'h00, sr};
			3: rd = QUERY_WORD;
			default: rd = rdmem(addr);
		endcase
	end
	// a released bus shows the inverse of its last value, never a lucky match
	always @(negedge rd_en) last <= rd;
	assign #(ACC_NS) dout_oe_n = !rd_en;
	assign #(ACC_NS) dout = rd_en ? rd : ~last;
	initial viol = 0;
	always @(negedge ce_n or negedge oe_n or negedge we_n) begin
		if (!ce_n && (!oe_n || !we_n)) begin
			if ($realtime < ready_t + `FLH_READ_REC_NS) viol++;
			if (!oe_n && !we_n) viol++;
		end
	end
	// ****************************************
	// commands, program and erase
	// ****************************************
	task automatic run(input bit erase, input int a, input logic [15:0] d);
		int id = op_id;
		fork
			begin
				#(BUSY_NS);
				if (id == op_id) begin
					if (erase) mem.delete();
					else mem[a] = rdmem(a) & d;
					busy = 0;
					sr = 8'h80;
				end
			end
		join_none
	endtask
	task automatic latch(input int a, input logic [15:0] d);
		if (pend == 8'h40 || pend == 8'h10 || (pend == 8'h20 && d[7:0] == 8'hd0)) begin
			mode = 2;
			if (vpp_low) begin
				sr = 8'h80 | VPP_ERR;
			end else begin
				busy = 1;
				sr = 8'h00;
				op_a = a;
				op_id++;
				run(pend == 8'h20, a, d);
			end
			pend = 8'h00;
		end else begin
			case (d[7:0])
				8'hff: mode = 0;
				8'h90: mode = 1;
				8'h70: mode = 2;
				8'h98: mode = 3;
				8'h50: sr = 8'h80;
				default: ;
			endcase
			pend = d[7:0];
		end
	endtask
	// first of the two strobes to rise closes the write
	always @(posedge we_n or posedge ce_n) begin
		if (rp_n && oe_n && (we_n ^ ce_n)) begin
			if (din_oe_n) viol++;
			latch(addr, din);
		end
	end
	always @(negedge rp_n) begin
		rp_fall = $realtime;
		sr = 8'h80;
		if (busy) begin
			mem[op_a] = 16'($urandom);
			busy = 0;
			op_id++;
			ready_t = $realtime + ABORT_NS;
		end
	end
	always @(posedge rp_n) begin
		if ($realtime - rp_fall < `FLH_RESET_PULSE_NS) viol++;
		mode = 0;
		pend = 8'h00;
		if (ready_t < $realtime) ready_t = $realtime;
	end
endmodule

// >>> sim/flh_host_ctrl_bench.sv
// Purpose: self-checking bench of the flash host controller
// Assumes: short abort windows; model timing well inside host waits
// Notes: expected array data kept in a shadow copy
`timescale 1ns/100ps
`include "flh_defs.svh"
module flh_host_ctrl_bench;
	// arbitrary id words
	localparam logic [15:0] MAKER_ID = 16'h00a5;
	localparam logic [15:0] QUERY_WORD = 16'h005a;
	logic CLOCK = 0, RST = 1, REQ_VALID = 0, REQ_WRITE = 0, REQ_RAW = 0, PWRDN = 0, vpp_low = 0;
	logic [21:0] REQ_ADDR = '0;
	logic [15:0] REQ_WDATA = '0;
	logic REQ_READY, RSP_VALID, OP_BUSY, ARRAY_MODE, CE_N, OE_N, WE_N, RP_N, DQ_OE_N, m_oe_n;
	logic [21:0] ADDR, a;
	logic [15:0] RSP_RDATA, DQ_O, m_dq, DQ_I, got, d;
	logic [15:0] shadow [int];
	int viol, err_count = 0, samples_checked = 0;
	assign DQ_I = !m_oe_n ? m_dq : (!DQ_OE_N ? DQ_O : m_dq);
	always #2.5 CLOCK = ~CLOCK;
	flh_host_ctrl #(.ABORT_ERASE_CYC(40), .ABORT_PROG_CYC(25)) flh_host_ctrl_i (.CLOCK, .RST,
		.REQ_VALID, .REQ_READY, .REQ_WRITE, .REQ_RAW, .REQ_ADDR, .REQ_WDATA, .RSP_VALID,
		.RSP_RDATA, .PWRDN, .OP_BUSY, .ARRAY_MODE, .CE_N, .OE_N, .WE_N, .RP_N, .ADDR, .DQ_O,
		.DQ_OE_N, .DQ_I);
	flh_flash_model #(.MAKER_ID(MAKER_ID), .QUERY_WORD(QUERY_WORD)) flh_flash_model_i (
		.ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N), .rp_n(RP_N), .addr(ADDR), .din(DQ_O),
		.din_oe_n(DQ_OE_N), .vpp_low, .dout(m_dq), .dout_oe_n(m_oe_n), .viol);
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk_bit(input string what, input logic g, input logic e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t %s got %b exp %b", $time, what, g, e);
		end
	endtask
	task automatic chk_word(input string what, input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask
	task automatic req(input bit w, input bit raw, input logic [21:0] ad, input logic [15:0] wd);
		int n = 0;
		REQ_WRITE = w;
		REQ_RAW = raw;
		REQ_ADDR = ad;
		REQ_WDATA = wd;
		REQ_VALID = 1;
		while (REQ_READY !== 1'b1 && n < 2000) begin
			@(negedge CLOCK);
			n++;
		end
		@(negedge CLOCK);
		REQ_VALID = 0;
		while (RSP_VALID !== 1'b1 && n < 4000) begin
			@(negedge CLOCK);
			n++;
		end
		chk_bit("answer", RSP_VALID, 1'b1);
		got = RSP_RDATA;
	endtask
	task automatic wait_done();
		int k = 0;
		do begin
			req(0, 1, 22'h0, 16'h0000);
			k++;
		end while (got[7] !== 1'b1 && k < 40);
		// the busy flag drops on the edge after the ready status answer
		@(negedge CLOCK);
		chk_bit("busy", OP_BUSY, 1'b0);
	endtask
	function automatic logic [15:0] mode_word(logic [7:0] c);
		return c == 8'h90 ? MAKER_ID : (c == 8'h98 ? QUERY_WORD : 16'h0080);
	endfunction
	function automatic logic [15:0] after_prog(int ad, logic [15:0] wd);
		return (shadow.exists(ad) ? shadow[ad] : 16'hffff) & wd;
	endfunction
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		#300000;
		err_count++;
		report_and_stop();
	end
	initial begin
		void'($urandom(10));
		repeat (3) @(negedge CLOCK);
		chk_bit("rp in reset", RP_N, 1'b0);
		chk_bit("ce in reset", CE_N, 1'b1);
		repeat (2) @(negedge CLOCK);
		RST = 0;
		for (int i = 0; i < 3; i++) begin
			d = i == 0 ? 16'h0090 : (i == 1 ? 16'h0098 : 16'h0070);
			req(1, 0, 22'($urandom), d);
			req(0, 1, 22'h0, 16'h0);
			chk_word("mode read", got, mode_word(d[7:0]));
		end
		for (int i = 0; i < 5; i++) begin
			if (i != 4) a = 22'($urandom);
			d = 16'($urandom);
			req(1, 0, a, i[0] ? 16'h0010 : 16'h0040);
			req(1, 0, a, d);
			shadow[a] = after_prog(a, d);
			chk_bit("busy set", OP_BUSY, 1'b1);
			wait_done();
			req(0, 0, a, 16'h0);
			chk_word("array read", got, shadow[a]);
		end
		vpp_low = 1;
		req(1, 0, a, 16'h0040);
		req(1, 0, a, 16'h0000);
		req(0, 1, a, 16'h0);
		chk_word("lockout status", got, 16'h0088);
		req(1, 0, a, 16'h0050);
		req(0, 1, a, 16'h0);
		chk_word("cleared status", got, 16'h0080);
		req(0, 0, a, 16'h0);
		chk_word("locked array", got, shadow[a]);
		vpp_low = 0;
		req(1, 0, a, 16'h0020);
		req(1, 0, a, 16'h00d0);
		@(negedge CLOCK);
		PWRDN = 1;
		// power-down is only taken once the post-write gap has run out
		repeat (8) @(negedge CLOCK);
		chk_bit("rp low", RP_N, 1'b0);
		chk_bit("deselect", CE_N, 1'b1);
		chk_bit("refused", REQ_READY, 1'b0);
		repeat (10) @(negedge CLOCK);
		PWRDN = 0;
		while (REQ_READY !== 1'b1) @(negedge CLOCK);
		chk_bit("array mode", ARRAY_MODE, 1'b1);
		chk_bit("busy clear", OP_BUSY, 1'b0);
		// device wakes in array mode, so status needs its read command first
		req(1, 0, a, 16'h0070);
		req(0, 1, a, 16'h0);
		chk_word("status wake", got, 16'h0080);
		req(1, 0, a, 16'h0020);
		req(1, 0, a, 16'h00d0);
		wait_done();
		shadow.delete();
		req(1, 0, a, 16'h0040);
		req(1, 0, a, 16'h1234);
		wait_done();
		req(0, 0, a, 16'h0);
		chk_word("array after program", got, 16'h1234);
		// leave the device in status mode so only the wake-up can restore array mode
		req(1, 0, a, 16'h0070);
		PWRDN = 1;
		while (RP_N !== 1'b0) @(negedge CLOCK);
		PWRDN = 0;
		req(0, 0, a, 16'h0);
		chk_word("read after wake", got, 16'h1234);
		chk_word("pin timing", 16'(viol), 16'h0000);
		report_and_stop();
	end
endmodule
